// >>> design/bpo_bridge_out.sv
`timescale 1ns/10ps
// Function
// - forward: A active, D modulated, B C inactive
// - reverse: C active, B modulated, A D inactive
// - direction change takes effect next pwm cycle
// - four counts early: blank B D, swap A C
// - no dead-band delay in full-bridge
// - shutdown sources: int pin low, comparator high
// - status bit reads 1 while a source is present
// - event sets status until firmware or restart clears
// - shutdown forces enabled pins to shutdown states
// - pairs A/C and B/D: high, low, high-z
// - shutdown input is level sensitive
// - status writes ignored while source present
// - restart resumes only at next period start
// - firmware writing 1 forces shutdown
// - auto-restart clears firmware-set status at once
// - auto-restart clears status once condition gone
// - dead-band delays only inactive-to-active edges
// - dead-band length from low seven bits
// - single mode drives pwm on steered pins
// - steered pin polarity from submode low bits
// - single mode: shutdown touches only steered pins
// - half-bridge: A pwm, B complement, delayed
// - dead-band beyond duty keeps output inactive
// - steering immediate or at next period start
module bpo_bridge_out
  import bpo_pkg::*;
(
  input  wire logic              aclk,            // 50 mhz instruction-cycle clock
  input  wire logic              aresetn,         // synchronous reset, active low
  input  wire logic [BPO_AW-1:0] s_axi_awaddr,    // write address
  input  wire logic              s_axi_awvalid,   // write address valid
  output wire logic              s_axi_awready,   // write address ready
  input  wire logic [31:0]       s_axi_wdata,     // write data
  input  wire logic [3:0]        s_axi_wstrb,     // write byte strobes
  input  wire logic              s_axi_wvalid,    // write data valid
  output wire logic              s_axi_wready,    // write data ready
  output wire logic [1:0]        s_axi_bresp,     // write response
  output wire logic              s_axi_bvalid,    // write response valid
  input  wire logic              s_axi_bready,    // write response ready
  input  wire logic [BPO_AW-1:0] s_axi_araddr,    // read address
  input  wire logic              s_axi_arvalid,   // read address valid
  output wire logic              s_axi_arready,   // read address ready
  output wire logic [31:0]       s_axi_rdata,     // read data
  output wire logic [1:0]        s_axi_rresp,     // read response
  output wire logic              s_axi_rvalid,    // read data valid
  input  wire logic              s_axi_rready,    // read data ready
  input  wire logic              pwm_base,        // base pwm waveform, same clock
  input  wire logic              period_start,    // pulse: first cycle of a period
  input  wire logic              dir_point,       // pulse: four counts before period end
  input  wire logic              ext_int_n_pin,   // external interrupt pin, async
  input  wire logic [1:0]        comparator_output, // comparator levels, async
  output wire logic [3:0]        bridge_out,      // pin levels d..a
  output wire logic [3:0]        bridge_oe        // pin drive enables d..a, high drives
);

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------

  // known register offsets; used by both write and read answers
  function automatic logic addr_ok(input logic [7:0] a);
    if (a == BPO_OFS_CTL) return 1'b1;
    else if (a == BPO_OFS_SD) return 1'b1;
    else if (a == BPO_OFS_DB) return 1'b1;
    else if (a == BPO_OFS_ST) return 1'b1;
    else if (a == BPO_OFS_STAT) return 1'b1;
    else return 1'b0;
  endfunction : addr_ok

  // source select: bit0 comparator 0, bit1 comparator 1, bit2 int pin
  function automatic logic sd_source(input logic [2:0] sel, input logic int_n,
                                     input logic c1, input logic c0);
    return (sel[2] & ~int_n) | (sel[1] & c1) | (sel[0] & c0);
  endfunction : sd_source

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  bpo_state_t state_ff;    // every flop of the block
  bpo_state_t nxt_state;   // next value

  logic       src;         // shutdown source level after sync
  logic       do_wr;       // register write happens this cycle
  logic       wr_ctl;      // write strobe, control
  logic       wr_sd;       // write strobe, shutdown control
  logic       wr_db;       // write strobe, dead-band
  logic       wr_st;       // write strobe, steering
  logic       full;        // full-bridge selected
  logic [3:0] act;         // logical active level per pin
  logic [3:0] en;          // pins owned by the pwm
  logic [3:0] lowp;        // active-low polarity per pin
  logic [7:0] rd_byte;     // read data byte

  assign src = sd_source(state_ff.sel, state_ff.sync2[2], state_ff.sync2[1],
                         state_ff.sync2[0]);
  assign full = state_ff.cfg[0];

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    act       = 4'h0;
    en        = 4'h0;
    rd_byte   = 8'h00;

    // pins and comparators pass two flops before use
    nxt_state.sync1 = {ext_int_n_pin, comparator_output};
    nxt_state.sync2 = state_ff.sync1;

    // -------- axi write channel --------
    // address and data are taken in either order; write once both held
    do_wr  = state_ff.aw_got && state_ff.w_got && !state_ff.bvalid;
    wr_ctl = do_wr && state_ff.w_lane && (state_ff.aw_addr == BPO_OFS_CTL);
    wr_sd  = do_wr && state_ff.w_lane && (state_ff.aw_addr == BPO_OFS_SD);
    wr_db  = do_wr && state_ff.w_lane && (state_ff.aw_addr == BPO_OFS_DB);
    wr_st  = do_wr && state_ff.w_lane && (state_ff.aw_addr == BPO_OFS_ST);
    if (state_ff.bvalid && s_axi_bready)
    begin
      nxt_state.bvalid = 1'b0;
    end
    if (s_axi_awvalid && state_ff.awready)
    begin
      nxt_state.aw_got  = 1'b1;
      nxt_state.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && state_ff.wready)
    begin
      nxt_state.w_got  = 1'b1;
      nxt_state.w_data = s_axi_wdata[7:0];
      nxt_state.w_lane = s_axi_wstrb[0];
    end
    if (do_wr)
    begin
      nxt_state.aw_got = 1'b0;
      nxt_state.w_got  = 1'b0;
      nxt_state.bvalid = 1'b1;
      nxt_state.bresp  = addr_ok(state_ff.aw_addr) ? BPO_RESP_OKAY : BPO_RESP_SLVERR;
    end
    // ready is registered from next-state values, so it drops on the capture edge
    nxt_state.awready = !nxt_state.aw_got && !nxt_state.bvalid;
    nxt_state.wready  = !nxt_state.w_got && !nxt_state.bvalid;

    // -------- register writes --------
    if (wr_ctl)
    begin
      nxt_state.cfg = state_ff.w_data[BPO_CFG_LSB +: 2];
      nxt_state.sub = state_ff.w_data[BPO_SUB_LSB +: 4];
    end
    if (wr_sd)
    begin
      nxt_state.sel   = state_ff.w_data[BPO_SEL_LSB +: 3];
      nxt_state.ss_ac = state_ff.w_data[BPO_AC_LSB +: 2];
      nxt_state.ss_bd = state_ff.w_data[BPO_BD_LSB +: 2];
    end
    if (wr_db)
    begin
      nxt_state.rs_en = state_ff.w_data[BPO_RS_BIT];
      nxt_state.db    = state_ff.w_data[6:0];
    end
    if (wr_st)
    begin
      nxt_state.st_sync = state_ff.w_data[BPO_SYNC_BIT];
      nxt_state.st_en   = state_ff.w_data[3:0];
    end

    // -------- shutdown event status --------
    // a live source always wins, so firmware cannot clear it early
    if (src)
    begin
      nxt_state.stat = 1'b1;
    end
    else if (wr_sd)
    begin
      // a firmware set is cleared at once when auto-restart is on
      nxt_state.stat = state_ff.w_data[BPO_STAT_BIT] & ~state_ff.rs_en;
    end
    else if (state_ff.rs_en)
    begin
      nxt_state.stat = 1'b0;
    end

    // -------- shutdown hold --------
    // hold covers the gap between status clearing and the next period
    if (src || state_ff.stat || (wr_sd && state_ff.w_data[BPO_STAT_BIT]))
    begin
      nxt_state.hold = 1'b1;
    end
    else if (period_start)
    begin
      nxt_state.hold = 1'b0;
    end

    // -------- enable: start only on a whole period --------
    if (state_ff.sub[3:2] != BPO_SUB_PWM)
    begin
      nxt_state.run = 1'b0;
    end
    else if (period_start)
    begin
      nxt_state.run = 1'b1;
    end

    // -------- direction --------
    if (!state_ff.run || !full)
    begin
      nxt_state.dir   = state_ff.cfg[1];
      nxt_state.blank = 1'b0;
    end
    else
    begin
      if (period_start)
      begin
        nxt_state.blank = 1'b0;
      end
      if (dir_point && (state_ff.cfg[1] != state_ff.dir))
      begin
        // swap the steady pair early, silence the modulated pair
        nxt_state.dir   = state_ff.cfg[1];
        nxt_state.blank = 1'b1;
      end
    end

    // -------- steering update --------
    if (!state_ff.st_sync)
    begin
      nxt_state.steer = state_ff.st_en;
    end
    else if (period_start)
    begin
      nxt_state.steer = state_ff.st_en;
    end

    // -------- dead-band, half-bridge only --------
    // a counter restarts on every rising edge, so a short pulse never
    // reaches the count and its output stays inactive
    for (int i = 0; i < 2; i++)
    begin
      if (((i == 0) ? pwm_base : ~pwm_base) == 1'b0 || state_ff.cfg != BPO_CFG_HALF)
      begin
        nxt_state.dbc[i] = 7'h00;
        nxt_state.dbo[i] = 1'b0;
      end
      else if (state_ff.dbc[i] < state_ff.db)
      begin
        nxt_state.dbc[i] = state_ff.dbc[i] + 7'h01;
        nxt_state.dbo[i] = 1'b0;
      end
      else
      begin
        nxt_state.dbo[i] = 1'b1;
      end
    end

    // -------- output mode --------
    case (bpo_cfg_t'(state_ff.cfg))
      BPO_CFG_SINGLE:
      begin
        act = {4{pwm_base}};
        en  = state_ff.steer;
      end
      BPO_CFG_HALF:
      begin
        act = {2'b00, state_ff.dbo[1], state_ff.dbo[0]};
        en  = 4'h3;
      end
      default:
      begin
        // no dead-band here: the raw waveform drives the modulated pin
        if (!state_ff.dir)
        begin
          act = {pwm_base & ~state_ff.blank, 2'b00, 1'b1};
        end
        else
        begin
          act = {1'b0, 1'b1, pwm_base & ~state_ff.blank, 1'b0};
        end
        en = 4'hF;
      end
    endcase

    // polarity: a and c follow bit 1, b and d bit 0
    lowp = {state_ff.sub[0], state_ff.sub[1], state_ff.sub[0], state_ff.sub[1]};
    nxt_state.pin = act ^ lowp;
    nxt_state.oe  = en;
    if (!state_ff.run)
    begin
      nxt_state.pin = 4'h0;
      nxt_state.oe  = 4'h0;
    end
    else if (state_ff.hold || src)
    begin
      // only pwm-owned pins are taken over by the shutdown state
      for (int k = 0; k < 4; k++)
      begin
        if (en[k])
        begin
          if ((k % 2) == 0)
          begin
            nxt_state.pin[k] = (state_ff.ss_ac == BPO_SS_HIGH);
            nxt_state.oe[k]  = (state_ff.ss_ac[1] == 1'b0);
          end
          else
          begin
            nxt_state.pin[k] = (state_ff.ss_bd == BPO_SS_HIGH);
            nxt_state.oe[k]  = (state_ff.ss_bd[1] == 1'b0);
          end
        end
      end
    end

    // -------- axi read channel --------
    if (state_ff.rvalid && s_axi_rready)
    begin
      nxt_state.rvalid = 1'b0;
    end
    if (s_axi_arvalid && state_ff.arready)
    begin
      if (s_axi_araddr == BPO_OFS_CTL)
        rd_byte = {state_ff.cfg, 2'b00, state_ff.sub};
      else if (s_axi_araddr == BPO_OFS_SD)
        rd_byte = {state_ff.stat, state_ff.sel, state_ff.ss_ac, state_ff.ss_bd};
      else if (s_axi_araddr == BPO_OFS_DB)
        rd_byte = {state_ff.rs_en, state_ff.db};
      else if (s_axi_araddr == BPO_OFS_ST)
        rd_byte = {3'b000, state_ff.st_sync, state_ff.st_en};
      else if (s_axi_araddr == BPO_OFS_STAT)
        rd_byte = {state_ff.run, state_ff.hold, state_ff.dir, state_ff.blank,
                   state_ff.oe};
      else
        rd_byte = 8'h00;
      nxt_state.rvalid = 1'b1;
      nxt_state.rdata  = {24'h000000, rd_byte};
      nxt_state.rresp  = addr_ok(s_axi_araddr) ? BPO_RESP_OKAY : BPO_RESP_SLVERR;
    end
    nxt_state.arready = !nxt_state.rvalid;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_ff       <= '0;
      state_ff.sync1 <= 3'h4;           // int pin idles high
      state_ff.sync2 <= 3'h4;
      state_ff.st_en <= BPO_STEER_RST;
      state_ff.steer <= BPO_STEER_RST;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign s_axi_awready = state_ff.awready;
  assign s_axi_wready  = state_ff.wready;
  assign s_axi_bvalid  = state_ff.bvalid;
  assign s_axi_bresp   = state_ff.bresp;
  assign s_axi_arready = state_ff.arready;
  assign s_axi_rvalid  = state_ff.rvalid;
  assign s_axi_rresp   = state_ff.rresp;
  assign s_axi_rdata   = state_ff.rdata;
  assign bridge_out    = state_ff.pin;
  assign bridge_oe     = state_ff.oe;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_fwd_drive: assert property (
    (state_ff.run && !state_ff.hold && !src && state_ff.cfg == 2'h1 && !state_ff.dir
     && !state_ff.blank && state_ff.sub[1:0] == 2'h0)
    |=> (bridge_oe == 4'hF && bridge_out[0] && !bridge_out[1] && !bridge_out[2]
         && bridge_out[3] == $past(pwm_base)))
    else $error("forward drive pattern wrong");

  chk_rev_drive: assert property (
    (state_ff.run && !state_ff.hold && !src && full && state_ff.dir
     && !state_ff.blank && state_ff.sub[1:0] == 2'h0)
    |=> (!bridge_out[0] && bridge_out[2] && !bridge_out[3]
         && bridge_out[1] == $past(pwm_base)))
    else $error("reverse drive pattern wrong");

  chk_dir_blank: assert property (
    (state_ff.run && full && dir_point && !period_start
     && state_ff.cfg[1] != state_ff.dir)
    |=> (state_ff.blank && state_ff.dir == $past(state_ff.cfg[1]))
    ##1 ($past(state_ff.hold) || $past(src) || !$past(full)
         || $past(state_ff.sub[1:0]) != 2'h0
         || (!bridge_out[1] && !bridge_out[3])))
    else $error("direction change did not blank modulated pins");

  chk_stat_set: assert property (
    src [*2] |-> state_ff.stat [*2])
    else $error("status bit not set by shutdown source");

  chk_stat_ignore: assert property (
    (src && wr_sd && !state_ff.w_data[BPO_STAT_BIT]) |=> state_ff.stat)
    else $error("status cleared while source present");

  chk_restart_clr: assert property (
    (state_ff.rs_en && !src && !wr_sd && !wr_db) |=> !state_ff.stat)
    else $error("auto-restart did not clear status");

  chk_hold_period: assert property (
    (state_ff.hold && !period_start) |=> state_ff.hold)
    else $error("output resumed before period start");

  chk_sd_pair: assert property (
    (state_ff.run && state_ff.hold && full && state_ff.ss_ac == 2'h1)
    |=> (bridge_out[0] && bridge_oe[0] && bridge_out[2]))
    else $error("pair a/c shutdown state wrong");

  chk_half_pins: assert property (
    (state_ff.run && !state_ff.hold && !src && state_ff.cfg == 2'h2) |=> bridge_oe == 4'h3)
    else $error("half-bridge must drive only a and b");

  chk_db_delay: assert property (
    (state_ff.cfg == 2'h2 && state_ff.db == 7'h02 && $rose(pwm_base) ##1 pwm_base [*2])
    |-> (!state_ff.dbo[0] ##1 state_ff.dbo[0]))
    else $error("dead-band delay length wrong");

  chk_steer_pins: assert property (
    (state_ff.run && !state_ff.hold && !src && state_ff.cfg == 2'h0)
    |=> bridge_oe == $past(state_ff.steer))
    else $error("steered pins not enabled");

  cov_dir_change: cover property (state_ff.run && dir_point && state_ff.cfg[1] != state_ff.dir
                                  && full);
  cov_shutdown: cover property (state_ff.run && $rose(state_ff.hold) ##[1:50] $fell(state_ff.hold));
  cov_steer_multi: cover property (state_ff.run && state_ff.cfg == 2'h0 && bridge_oe == 4'hF);

endmodule : bpo_bridge_out

// >>> pkg/bpo_pkg.sv
package bpo_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on the axi4-lite slave)
  // ----------------------------------------------------------------
  localparam int          BPO_AW          = 8;         // register address width
  localparam logic [7:0]  BPO_OFS_CTL     = 8'h00;     // pwm_control_reg
  localparam logic [7:0]  BPO_OFS_SD      = 8'h04;     // shutdown_control_reg
  localparam logic [7:0]  BPO_OFS_DB      = 8'h08;     // deadband_control_reg
  localparam logic [7:0]  BPO_OFS_ST      = 8'h0C;     // steering_control_reg
  localparam logic [7:0]  BPO_OFS_STAT    = 8'h10;     // read-only live state

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int          BPO_CFG_LSB     = 6;         // output_config_field [7:6]
  localparam int          BPO_SUB_LSB     = 0;         // pwm_submode_field [3:0]
  localparam int          BPO_STAT_BIT    = 7;         // shutdown_event_status
  localparam int          BPO_SEL_LSB     = 4;         // shutdown_source_select [6:4]
  localparam int          BPO_AC_LSB      = 2;         // pair_ac_shutdown_state [3:2]
  localparam int          BPO_BD_LSB      = 0;         // pair_bd_shutdown_state [1:0]
  localparam int          BPO_RS_BIT      = 7;         // auto_restart_enable
  localparam int          BPO_SYNC_BIT    = 4;         // steering_sync_select

  // ----------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------
  localparam logic [3:0]  BPO_STEER_RST   = 4'h1;      // steering_enable_bits after reset
  localparam logic [1:0]  BPO_SUB_PWM     = 2'h3;      // submode upper bits: pwm on
  localparam logic [1:0]  BPO_SS_LOW      = 2'h0;      // shutdown state: drive 0
  localparam logic [1:0]  BPO_SS_HIGH     = 2'h1;      // shutdown state: drive 1
  localparam logic [1:0]  BPO_RESP_OKAY   = 2'h0;      // axi okay
  localparam logic [1:0]  BPO_RESP_SLVERR = 2'h2;      // axi slave error

  // output_config_field codes
  typedef enum logic [1:0] {
    BPO_CFG_SINGLE = 2'h0,
    BPO_CFG_FWD    = 2'h1,
    BPO_CFG_HALF   = 2'h2,
    BPO_CFG_REV    = 2'h3
  } bpo_cfg_t;

  // complete block state, registered as one word
  typedef struct packed {
    logic [2:0]       sync1;     // int_n, cmp1, cmp0 first stage
    logic [2:0]       sync2;     // second stage
    logic [1:0]       cfg;       // output_config_field
    logic [3:0]       sub;       // pwm_submode_field
    logic             stat;      // shutdown_event_status
    logic [2:0]       sel;       // shutdown_source_select
    logic [1:0]       ss_ac;     // pair_ac_shutdown_state
    logic [1:0]       ss_bd;     // pair_bd_shutdown_state
    logic             rs_en;     // auto_restart_enable
    logic [6:0]       db;        // deadband_count
    logic             st_sync;   // steering_sync_select
    logic [3:0]       st_en;     // steering_enable_bits (as written)
    logic [3:0]       steer;     // steering in effect
    logic             run;       // pwm output running
    logic             hold;      // outputs held in shutdown state
    logic             dir;       // direction in effect (1 = reverse)
    logic             blank;     // modulated outputs forced off
    logic [1:0][6:0]  dbc;       // dead-band counters a, b
    logic [1:0]       dbo;       // dead-band delayed actives a, b
    logic [3:0]       pin;       // pin levels d..a
    logic [3:0]       oe;        // pin enables d..a
    logic             aw_got;    // write address held
    logic [7:0]       aw_addr;   // held write address
    logic             w_got;     // write data held
    logic [7:0]       w_data;    // held write byte
    logic             w_lane;    // byte lane 0 strobe
    logic             awready;   // axi awready
    logic             wready;    // axi wready
    logic             bvalid;    // axi bvalid
    logic [1:0]       bresp;     // axi bresp
    logic             arready;   // axi arready
    logic             rvalid;    // axi rvalid
    logic [1:0]       rresp;     // axi rresp
    logic [31:0]      rdata;     // axi rdata
  } bpo_state_t;

endpackage : bpo_pkg

// >>> dv/bpo_switch_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// power switch driver inputs
// ----------------------------------------
module bpo_switch_model
  import bpo_pkg::*;
(
  input  wire logic       aclk,       // instruction-cycle clock
  input  wire logic [3:0] bridge_out, // pin levels d..a
  input  wire logic [3:0] bridge_oe,  // pin enables d..a
  output wire logic [3:0] pin_level   // level seen by the switches
);
  logic [3:0] last_ff = 4'h0;         // level of the previous cycle
  // a floating pin toggles every cycle, so a stale level never passes
  always @(posedge aclk)
    last_ff <= pin_level;
  assign pin_level = (bridge_oe & bridge_out) | (~bridge_oe & ~last_ff);
endmodule : bpo_switch_model

// >>> dv/testbench.sv
`timescale 1ns/10ps
module testbench
  import bpo_pkg::*;
;
  logic        aclk = 0, aresetn, awv, wv, bready, arv, rready, pwm, ps, dp, int_n;
  logic [7:0]  awaddr, araddr;        // bus addresses
  logic [31:0] wdata, d;              // write and read words
  logic [1:0]  cmp, r;                // comparator levels, response
  wire  logic  awr, wr_, bv, arr, rv; // slave handshakes
  wire  logic [1:0]  bresp, rresp;    // slave responses
  wire  logic [31:0] rdata;           // read word
  wire  logic [3:0]  bout, boe, lvl;  // pins d..a
  int          n_errors = 0, n_compared = 0;
  always #10 aclk = ~aclk;
  bpo_bridge_out dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
    .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rready), .pwm_base(pwm), .period_start(ps), .dir_point(dp),
    .ext_int_n_pin(int_n), .comparator_output(cmp), .bridge_out(bout), .bridge_oe(boe));
  bpo_switch_model sw_u (.aclk(aclk), .bridge_out(bout), .bridge_oe(boe), .pin_level(lvl));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      n_errors++;
      $display("unexpected %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task give_verdict;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  // a handshake that never came ends the run
  task wt(input logic c);
    if (c !== 1'b1)
    begin
      n_errors++;
      give_verdict();
    end
  endtask : wt
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata  <= {24'h0, v};
    awv    <= 1'b1;
    wv     <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i < 40; i++)
    begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr_) wv <= 1'b0;
      if (bv) break;
    end
    r = bresp;
    bready <= 1'b0;
    wt(bv);
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arv    <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i < 40; i++)
    begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
      if (rv) break;
    end
    d = rdata;
    rready <= 1'b0;
    wt(rv);
  endtask : rd
  // one-cycle timer pulse, then let the pins settle
  task pulse(input logic is_dir);
    @(posedge aclk);
    if (is_dir) dp <= 1'b1; else ps <= 1'b1;
    @(posedge aclk);
    dp <= 1'b0;
    ps <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask : pulse
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_fwd;
    wr(BPO_OFS_CTL, 8'h4C);
    pwm <= 1'b1;
    pulse(1'b0);
    chk("fwd high", bout, 4'b1001);
    pwm <= 1'b0;
    repeat (4) @(posedge aclk);
    chk("fwd low", bout, 4'b0001);
  endtask : t_fwd
  task t_rev;
    pwm <= 1'b1;
    wr(BPO_OFS_CTL, 8'hCC);
    repeat (4) @(posedge aclk);
    chk("dir held", bout, 4'b1001);
    pulse(1'b1);
    chk("dir blank", bout, 4'b0100);
    pulse(1'b0);
    chk("rev", bout, 4'b0110);
  endtask : t_rev
  task t_sd;
    wr(BPO_OFS_SD, 8'h16);
    cmp <= 2'b01;
    repeat (6) @(posedge aclk);
    chk("sd oe", boe, 4'b0101);
    chk("sd lvl", {lvl[2], lvl[0]}, 2'b11);
    wr(BPO_OFS_SD, 8'h16);
    rd(BPO_OFS_SD);
    chk("stat held", d, 32'h96);
    cmp <= 2'b00;
    repeat (6) @(posedge aclk);
    rd(BPO_OFS_SD);
    chk("stat kept", d, 32'h96);
    wr(BPO_OFS_SD, 8'h16);
    chk("still off", boe, 4'b0101);
    pulse(1'b0);
    chk("resume", {boe, bout}, 8'hF6);
    wr(BPO_OFS_SD, 8'h96);
    repeat (4) @(posedge aclk);
    chk("fw sd", boe, 4'b0101);
    wr(8'h20, 8'h00);
    chk("unmapped", r, BPO_RESP_SLVERR);
  endtask : t_sd
  task t_half;
    logic seen;
    wr(BPO_OFS_DB, 8'h82);
    wr(BPO_OFS_CTL, 8'h8C);
    rd(BPO_OFS_SD);
    chk("restart clr", d, 32'h16);
    pwm <= 1'b0;
    pulse(1'b0);
    chk("half b", {boe, bout}, 8'h32);
    pwm <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("dead band", bout, 4'h0);
    repeat (2) @(posedge aclk);
    chk("half a", bout, 4'h1);
    pwm <= 1'b0;
    repeat (4) @(posedge aclk);
    pwm <= 1'b1;
    seen = 1'b0;
    repeat (2) @(posedge aclk);
    pwm <= 1'b0;
    repeat (4)
    begin
      @(posedge aclk);
      seen = seen | bout[0];
    end
    chk("short pulse", seen, 1'b0);
  endtask : t_half
  task t_steer;
    wr(BPO_OFS_ST, 8'h05);
    wr(BPO_OFS_CTL, 8'h0E);
    pwm <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("steer now", {boe, bout}, 8'h5A);
    wr(BPO_OFS_ST, 8'h1A);
    chk("steer wait", boe, 4'h5);
    pulse(1'b0);
    chk("steer sync", {boe, bout}, 8'hAA);
    wr(BPO_OFS_SD, 8'h44);
    int_n <= 1'b0;
    repeat (6) @(posedge aclk);
    chk("steer sd", {boe, bout}, 8'hA0);
    rd(BPO_OFS_SD);
    chk("stat live", d, 32'hC4);
    int_n <= 1'b1;
    repeat (6) @(posedge aclk);
    rd(BPO_OFS_SD);
    chk("auto clr", d, 32'h44);
    chk("wait period", bout, 4'h0);
    pulse(1'b0);
    chk("auto resume", bout, 4'hA);
    wr(BPO_OFS_SD, 8'hC4);
    rd(BPO_OFS_SD);
    chk("fw set clr", d, 32'h44);
    chk("fw set held", bout, 4'h0);
  endtask : t_steer
  initial
  begin
    {aresetn, awv, wv, bready, arv, rready, pwm, ps, dp, cmp} = '0;
    {awaddr, araddr, wdata} = '0;
    int_n = 1'b1;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("reset pins", {boe, bout}, 8'h00);
    t_fwd();
    t_rev();
    t_sd();
    t_half();
    t_steer();
    give_verdict();
  end
endmodule : testbench
